//--- rtl/axis_homing_sequencer.sv
// Purpose: Homing sequencer for one servo axis.
// Assumes: Profile reports idle and commanded-at-target on ref_clk.
// Notes:   Home switch and marker arrive from pins and are synchronised.
//
// Functional notes
// (RQ1) Switch method only on axes 1-4, motor feedback.
// (RQ2) Switch gates search; first negative marker is home.
// (RQ3) Switch low positive side, high negative side.
// (RQ4) Cycle starts on execute rising edge only.
// (RQ5) Released starts negative fast; actuated starts positive.
// (RQ6) Negative fast until switch actuates, then stop.
// (RQ7) Positive fast until switch releases, then stop.
// (RQ8) Negative slow to switch, continue until marker latches.
// (RQ9) After marker, decelerate and stop beyond it.
// (RQ10) Fast move to reference plus shift distance.
// (RQ11) Load commanded home, actual home minus following error.
// (RQ12) Set established flag when switch method completes.
// (RQ13) Switch method final marker approach always travels negative.
// (RQ14) Marker methods: first marker in chosen direction.
// (RQ15) Marker methods run slow in chosen direction.
// (RQ16) Marker methods stop beyond marker with deceleration.
// (RQ17) Marker methods then fast move to reference plus shift.
// (RQ18) Marker methods load both positions; set established.
// (RQ19) Done asserts when commanded position reaches home.
// (RQ20) Superseded flag when another command aborts homing.
// (RQ21) Marker edge armed only in marker search phases.
`timescale 1ns/1ps

module axis_homing_sequencer (
  input  wire logic                          ref_clk,
  input  wire logic                          rstn,
  input  wire logic [homing_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [homing_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [homing_pkg::DATA_W-1:0] reg_rdata,
  input  wire logic                          home_switch,
  input  wire logic                          marker_pulse,
  input  wire logic [3:0]                    axis_number,
  input  wire logic                          motor_feedback,
  input  wire logic                          profile_idle,
  input  wire logic                          cmd_at_target,
  input  wire logic [homing_pkg::POS_W-1:0]  actual_position,
  input  wire logic [homing_pkg::POS_W-1:0]  following_error,
  input  wire logic                          supersede_req,
  output homing_pkg::motion_cmd_type         motion_cmd,
  output homing_pkg::pos_load_type           pos_load,
  output logic                               homing_busy,
  output logic                               homing_done,
  output logic                               position_established_flag,
  output logic                               superseded_flag,
  output logic                               method_error
);
  import homing_pkg::*;

  // ==========================================================================
  // Module state.
  typedef struct packed {
    seq_state_type            st;
    logic [1:0]               sw_sync;
    logic [2:0]               mk_sync;
    logic                     exec_bit;
    logic                     exec_prev;
    homing_method_select_type method;
    logic [POS_W-1:0]         fast_seek_speed;
    logic [POS_W-1:0]         slow_seek_speed;
    logic [POS_W-1:0]         home_shift_distance;
    logic [POS_W-1:0]         home_position;
    logic [POS_W-1:0]         marker_pos;
    motion_cmd_type           cmd;
    pos_load_type             load;
    logic                     busy;
    logic                     done;
    logic                     established;
    logic                     superseded;
    logic                     err;
    logic [DATA_W-1:0]        rdata;
  } state_type;

  state_type s_q;
  state_type s_d;

  // ==========================================================================
  // Helpers.
  function automatic motion_cmd_type velocity_cmd(
    input logic             neg,
    input logic [POS_W-1:0] spd
  );
    motion_cmd_type c;
    c        = '0;
    c.run    = 1'b1;
    c.dir    = neg;
    c.speed  = spd;
    return c;
  endfunction : velocity_cmd

  function automatic motion_cmd_type stop_cmd();
    motion_cmd_type c;
    c      = '0;
    c.stop = 1'b1;
    return c;
  endfunction : stop_cmd

  function automatic logic switch_allowed(
    input logic [3:0] axis,
    input logic       fb
  );
    return fb && (axis >= AXIS_FIRST) && (axis <= AXIS_LAST);
  endfunction : switch_allowed

  // ==========================================================================
  // Derived signals.
  logic switch_on;
  logic marker_edge;
  logic exec_rise;
  logic wr_ctrl;
  logic [DATA_W-1:0] status_word;

  always_comb begin
    switch_on   = s_q.sw_sync[1];                            // RQ3
    marker_edge = s_q.mk_sync[1] & ~s_q.mk_sync[2];           // RQ21
    exec_rise   = s_q.exec_bit & ~s_q.exec_prev;              // RQ4
    wr_ctrl     = reg_wr && (reg_addr == CTRL_OFS);
    status_word = '0;
    status_word[ST_BUSY_BIT]   = s_q.busy;
    status_word[ST_DONE_BIT]   = s_q.done;
    status_word[ST_ESTAB_BIT]  = s_q.established;
    status_word[ST_SUPER_BIT]  = s_q.superseded;
    status_word[ST_ERROR_BIT]  = s_q.err;
    status_word[ST_SWITCH_BIT] = switch_on;
    status_word[ST_STATE_LSB +: 11] = s_q.st;
  end

  // ==========================================================================
  // Next state.
  always_comb begin
    s_d           = s_q;
    s_d.sw_sync   = {s_q.sw_sync[0], home_switch};
    s_d.mk_sync   = {s_q.mk_sync[1:0], marker_pulse};
    s_d.exec_prev = s_q.exec_bit;
    s_d.load.load = 1'b0;

    // Register writes.
    if (reg_wr) begin
      case (reg_addr)
        CTRL_OFS: begin
          s_d.exec_bit = reg_wdata[CTRL_EXEC_BIT];
          if (!s_q.busy) begin
            s_d.method = homing_method_select_type'(
              reg_wdata[CTRL_METHOD_LSB +: 2]);
          end
        end
        FAST_OFS:  s_d.fast_seek_speed     = reg_wdata;
        SLOW_OFS:  s_d.slow_seek_speed     = reg_wdata;
        SHIFT_OFS: s_d.home_shift_distance = reg_wdata;
        HOME_OFS:  s_d.home_position       = reg_wdata;
        default: begin
        end
      endcase
    end

    // Register reads, answered in the next cycle.
    s_d.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        CTRL_OFS: begin
          s_d.rdata[CTRL_EXEC_BIT]         = s_q.exec_bit;
          s_d.rdata[CTRL_METHOD_LSB +: 2]  = s_q.method;
        end
        FAST_OFS:   s_d.rdata = s_q.fast_seek_speed;
        SLOW_OFS:   s_d.rdata = s_q.slow_seek_speed;
        SHIFT_OFS:  s_d.rdata = s_q.home_shift_distance;
        HOME_OFS:   s_d.rdata = s_q.home_position;
        STATUS_OFS: s_d.rdata = status_word;
        MARKER_OFS: s_d.rdata = s_q.marker_pos;
        default:    s_d.rdata = '0;
      endcase
    end

    // Sequencer.
    case (s_q.st)
      ST_IDLE: begin
        if (exec_rise) begin                                   // RQ4
          s_d.done       = 1'b0;
          s_d.superseded = 1'b0;
          s_d.err        = 1'b0;
          if (s_q.method == switch_then_marker_method) begin
            if (!switch_allowed(axis_number, motor_feedback)) begin // RQ1
              s_d.err = 1'b1;
            end else begin
              s_d.busy        = 1'b1;
              s_d.established = 1'b0;
              if (switch_on) begin                             // RQ5
                s_d.st  = ST_POS_FAST;
                s_d.cmd = velocity_cmd(1'b0, s_q.fast_seek_speed);
              end else begin
                s_d.st  = ST_NEG_FAST;
                s_d.cmd = velocity_cmd(1'b1, s_q.fast_seek_speed);
              end
            end
          end else if (s_q.method == marker_positive_method ||
                       s_q.method == marker_negative_method) begin
            s_d.busy        = 1'b1;
            s_d.established = 1'b0;
            s_d.st          = ST_MARK_SRCH;                    // RQ14
            s_d.cmd = velocity_cmd(                            // RQ15
              s_q.method == marker_negative_method, s_q.slow_seek_speed);
          end else begin
            s_d.err = 1'b1;
          end
        end
      end
      ST_NEG_FAST: begin
        if (switch_on) begin                                   // RQ6
          s_d.st  = ST_STOP_NEG;
          s_d.cmd = stop_cmd();
        end
      end
      ST_STOP_NEG: begin
        if (profile_idle) begin                                // RQ7
          s_d.st  = ST_POS_FAST;
          s_d.cmd = velocity_cmd(1'b0, s_q.fast_seek_speed);
        end
      end
      ST_POS_FAST: begin
        if (!switch_on) begin                                  // RQ7
          s_d.st  = ST_STOP_POS;
          s_d.cmd = stop_cmd();
        end
      end
      ST_STOP_POS: begin
        if (profile_idle) begin                                // RQ13
          s_d.st  = ST_NEG_SLOW;
          s_d.cmd = velocity_cmd(1'b1, s_q.slow_seek_speed);   // RQ8
        end
      end
      ST_NEG_SLOW: begin
        if (switch_on) begin                                   // RQ2
          s_d.st = ST_SW_MARK;
        end
      end
      ST_SW_MARK, ST_MARK_SRCH: begin
        if (marker_edge) begin                                 // RQ8
          s_d.marker_pos = actual_position;                    // RQ14
          s_d.st         = ST_STOP_MARK;
          s_d.cmd        = stop_cmd();                         // RQ9
        end
      end
      ST_STOP_MARK: begin
        if (profile_idle) begin                                // RQ16
          s_d.st         = ST_SHIFT;
          s_d.cmd        = '0;
          s_d.cmd.move   = 1'b1;                               // RQ10
          s_d.cmd.speed  = s_q.fast_seek_speed;                // RQ17
          s_d.cmd.target = s_q.marker_pos + s_q.home_shift_distance;
        end
      end
      ST_SHIFT: begin
        if (cmd_at_target && profile_idle) begin               // RQ17
          s_d.st           = ST_LOAD;
          s_d.cmd          = '0;
          s_d.load.load    = 1'b1;
          s_d.load.cmd_pos = s_q.home_position;                // RQ11
          if (s_q.method == switch_then_marker_method) begin
            s_d.load.act_pos = s_q.home_position - following_error; // RQ11
          end else begin
            s_d.load.act_pos = s_q.home_position;              // RQ18
          end
        end
      end
      ST_LOAD: begin
        s_d.st          = ST_IDLE;
        s_d.busy        = 1'b0;
        s_d.done        = 1'b1;                                // RQ19
        s_d.established = 1'b1;                                // RQ12 RQ18
      end
      default: begin
        s_d.st   = ST_IDLE;
        s_d.cmd  = '0;
        s_d.busy = 1'b0;
      end
    endcase

    // Another motion command takes the axis over.
    if (supersede_req && s_q.busy) begin                       // RQ20
      s_d.st         = ST_IDLE;
      s_d.busy       = 1'b0;
      s_d.superseded = 1'b1;
      s_d.cmd        = '0;
      s_d.load.load  = 1'b0;
    end

    // A write to control never touches the result flags directly.
    if (wr_ctrl && !s_q.busy && !exec_rise) begin
      s_d.err = s_d.err;
    end
  end

  // ==========================================================================
  // State register.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s_q                     <= '0;
      s_q.st                  <= ST_IDLE;
      s_q.method              <= switch_then_marker_method;
      s_q.fast_seek_speed     <= FAST_RST;
      s_q.slow_seek_speed     <= SLOW_RST;
      s_q.home_shift_distance <= SHIFT_RST;
      s_q.home_position       <= HOME_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // Outputs.
  always_comb begin
    reg_rdata                 = s_q.rdata;
    motion_cmd                = s_q.cmd;
    pos_load                  = s_q.load;
    homing_busy               = s_q.busy;
    homing_done               = s_q.done;
    position_established_flag = s_q.established;
    superseded_flag           = s_q.superseded;
    method_error              = s_q.err;
  end

endmodule : axis_homing_sequencer

//--- rtl/homing_pkg.sv
// Purpose: Shared constants and carrier types for the axis homing sequencer.
// Assumes: 32-bit positions and speeds in user units, word-wide registers.
// Notes:   Register offsets are byte addresses of aligned 32-bit words.
package homing_pkg;

  // ==========================================================================
  // Widths.
  localparam int unsigned POS_W  = 32;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // ==========================================================================
  // Register offsets.
  localparam logic [ADDR_W-1:0] CTRL_OFS   = 8'h00;
  localparam logic [ADDR_W-1:0] FAST_OFS   = 8'h04;
  localparam logic [ADDR_W-1:0] SLOW_OFS   = 8'h08;
  localparam logic [ADDR_W-1:0] SHIFT_OFS  = 8'h0c;
  localparam logic [ADDR_W-1:0] HOME_OFS   = 8'h10;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h14;
  localparam logic [ADDR_W-1:0] MARKER_OFS = 8'h18;

  // ==========================================================================
  // Control register fields.
  localparam int unsigned CTRL_EXEC_BIT   = 0;
  localparam int unsigned CTRL_METHOD_LSB = 1;

  // Status register fields.
  localparam int unsigned ST_BUSY_BIT   = 0;
  localparam int unsigned ST_DONE_BIT   = 1;
  localparam int unsigned ST_ESTAB_BIT  = 2;
  localparam int unsigned ST_SUPER_BIT  = 3;
  localparam int unsigned ST_ERROR_BIT  = 4;
  localparam int unsigned ST_SWITCH_BIT = 5;
  localparam int unsigned ST_STATE_LSB  = 8;

  // ==========================================================================
  // Reset values.
  localparam logic [POS_W-1:0] FAST_RST  = 32'h0000_07d0;
  localparam logic [POS_W-1:0] SLOW_RST  = 32'h0000_01f4;
  localparam logic [POS_W-1:0] SHIFT_RST = 32'h0000_0000;
  localparam logic [POS_W-1:0] HOME_RST  = 32'h0000_0000;

  // Axes that may use the switch-then-marker method.
  localparam logic [3:0] AXIS_FIRST = 4'h1;
  localparam logic [3:0] AXIS_LAST  = 4'h4;

  // ==========================================================================
  // Homing methods.
  typedef enum logic [1:0] {
    switch_then_marker_method = 2'h0,
    marker_positive_method    = 2'h1,
    marker_negative_method    = 2'h2
  } homing_method_select_type;

  // Sequencer states, one-hot.
  typedef enum logic [10:0] {
    ST_IDLE      = 11'h001,
    ST_NEG_FAST  = 11'h002,
    ST_STOP_NEG  = 11'h004,
    ST_POS_FAST  = 11'h008,
    ST_STOP_POS  = 11'h010,
    ST_NEG_SLOW  = 11'h020,
    ST_SW_MARK   = 11'h040,
    ST_MARK_SRCH = 11'h080,
    ST_STOP_MARK = 11'h100,
    ST_SHIFT     = 11'h200,
    ST_LOAD      = 11'h400
  } seq_state_type;

  // ==========================================================================
  // Command to the motion profile; dir high means negative travel.
  typedef struct packed {
    logic             run;
    logic             stop;
    logic             move;
    logic             dir;
    logic [POS_W-1:0] speed;
    logic [POS_W-1:0] target;
  } motion_cmd_type;

  // Position load toward the axis.
  typedef struct packed {
    logic             load;
    logic [POS_W-1:0] cmd_pos;
    logic [POS_W-1:0] act_pos;
  } pos_load_type;

endpackage : homing_pkg

//--- tb/axis_homing_sequencer_properties.sv
// Purpose: Port assertions for the axis homing sequencer.
// Assumes: One clock domain, reset active low.
// Notes:   Attached to every sequencer instance by bind.
`timescale 1ns/1ps

module homing_checker (
  input logic                       ref_clk,
  input logic                       rstn,
  input logic                       reg_wr,
  input logic                       cmd_at_target,
  input logic                       supersede_req,
  input homing_pkg::motion_cmd_type motion_cmd,
  input homing_pkg::pos_load_type   pos_load,
  input logic                       homing_busy,
  input logic                       homing_done,
  input logic                       position_established_flag,
  input logic                       superseded_flag,
  input logic                       method_error
);
  import homing_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  // ==========================================================================
  // Sequencing.
  super_abort_a: assert property (
    supersede_req && homing_busy |=> !homing_busy && superseded_flag
    && motion_cmd == '0) else $error("abort left the axis moving");
  load_pulse_a: assert property (
    pos_load.load |=> !pos_load.load && homing_done && !homing_busy
    && position_established_flag) else $error("load did not complete");
  done_cause_a: assert property (
    $rose(homing_done) |-> $past(pos_load.load))
    else $error("done without a position load");
  load_target_a: assert property (
    pos_load.load |-> $past(cmd_at_target) || $past(cmd_at_target, 2))
    else $error("load before the commanded target");
  start_write_a: assert property (
    $rose(homing_busy) |-> $past(reg_wr, 2) || $past(reg_wr, 3)
    || $past(reg_wr, 4)) else $error("start without an execute write");
  error_halt_a: assert property (
    method_error |-> !homing_busy && !motion_cmd.run && !motion_cmd.move)
    else $error("refused start still moves");
  run_stop_a: assert property (
    homing_busy && motion_cmd.run ##1 homing_busy && !motion_cmd.run
    |-> motion_cmd.stop) else $error("run ended without a stop");
  move_stop_a: assert property (
    $rose(motion_cmd.move) |-> $past(motion_cmd.stop))
    else $error("offset move not after a stop");
endmodule : homing_checker

bind axis_homing_sequencer homing_checker u_homing_checker (.*);

//--- tb/servo_axis_model.sv
// Purpose: Behavioural servo axis with home switch and encoder marker.
// Assumes: One count of travel per clock while moving.
// Notes:   A stop coasts three counts, so it lands past a marker.
`timescale 1ns/1ps

module servo_axis_model #(
  parameter int SW_POS = 100
) (
  input  logic                       ref_clk,
  input  logic                       rstn,
  input  homing_pkg::motion_cmd_type cmd,
  input  logic                       place,
  input  logic [31:0]                place_pos,
  output logic                       home_switch,
  output logic                       marker_pulse,
  output logic                       profile_idle,
  output logic                       cmd_at_target,
  output logic [31:0]                actual_position
);
  import homing_pkg::*;
  logic signed [31:0] pos_q;
  logic [1:0]         coast_q;
  logic               neg_q;

  // ==========================================================================
  // Travel.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pos_q <= 32'sh12c;
      coast_q <= 2'h0;
      neg_q <= 1'b0;
    end else if (place) begin
      pos_q <= place_pos;
    end else if (cmd.run) begin
      pos_q <= cmd.dir ? pos_q - 32'sh1 : pos_q + 32'sh1;
      neg_q <= cmd.dir;
      coast_q <= 2'h3;
    end else if (cmd.move && pos_q != cmd.target) begin
      pos_q <= pos_q > $signed(cmd.target) ? pos_q - 32'sh1 : pos_q + 32'sh1;
    end else if (coast_q != 2'h0) begin
      pos_q <= neg_q ? pos_q - 32'sh1 : pos_q + 32'sh1;
      coast_q <= coast_q - 2'h1;
    end
  end

  assign home_switch     = pos_q < SW_POS;
  assign marker_pulse    = pos_q[5:0] == 6'h00;
  assign cmd_at_target   = cmd.move && pos_q == cmd.target;
  assign profile_idle    = !cmd.run && coast_q == 2'h0
                           && (!cmd.move || pos_q == cmd.target);
  assign actual_position = pos_q;
endmodule : servo_axis_model

//--- tb/tb_axis_homing_sequencer.sv
// Purpose: Self-checking bench for the axis homing sequencer.
// Assumes: Axis model moves one count per clock.
// Notes:   The latched marker may trail the pulse by a few counts.
`timescale 1ns/1ps

module tb_axis_homing_sequencer;
  import homing_pkg::*;
  logic           ref_clk, rstn, reg_wr, reg_rd, motor_feedback;
  logic           supersede_req, place, home_switch, marker_pulse;
  logic           profile_idle, cmd_at_target, homing_busy, homing_done;
  logic           position_established_flag, superseded_flag, method_error;
  logic [7:0]     reg_addr;
  logic [3:0]     axis_number;
  logic [31:0]    reg_wdata, reg_rdata, actual_position, following_error;
  logic [31:0]    place_pos, rv, shift, home, d;
  motion_cmd_type motion_cmd;
  pos_load_type   pos_load;
  int             n_fail, checks_done, seed, n;
  int             ax[4] = '{5, 1, 0, 2};
  int             me[4] = '{0, 0, 0, 3};

  axis_homing_sequencer u_axis_homing_sequencer (.*);
  servo_axis_model u_servo_axis_model (
    .ref_clk(ref_clk), .rstn(rstn), .cmd(motion_cmd), .place(place),
    .place_pos(place_pos), .home_switch(home_switch),
    .marker_pulse(marker_pulse), .profile_idle(profile_idle),
    .cmd_at_target(cmd_at_target), .actual_position(actual_position)
  );

  // ==========================================================================
  // Tasks.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask : rd
  task automatic start(input int m);
    wr(CTRL_OFS, 32'(m) << 1);
    wr(CTRL_OFS, (32'(m) << 1) | 32'h1);
  endtask : start
  task automatic wait_on(input logic ld);
    n = 0;
    do begin
      @(posedge ref_clk);
      #1 n++;
      if (n > 4000) begin
        n_fail++;
        wrap_up();
      end
    end while ((ld ? pos_load.load : motion_cmd.run) !== 1'b1);
  endtask : wait_on
  task automatic home_run(input int m, sp, mk, dir, input logic [31:0] spd);
    @(posedge ref_clk);
    place_pos <= sp;
    place <= 1'b1;
    @(posedge ref_clk);
    place <= 1'b0;
    start(m);
    wait_on(1'b0);
    chk(motion_cmd.dir, dir);
    chk(motion_cmd.speed, spd);
    wait_on(1'b1);
    chk(pos_load.cmd_pos, home);
    chk(pos_load.act_pos, m == 0 ? home - following_error : home);
    @(posedge ref_clk);
    #1 chk(position_established_flag, 32'h1);
    chk(homing_done, 32'h1);
    chk(homing_busy, 32'h0);
    rd(MARKER_OFS);
    d = m == 1 ? rv - mk : mk - rv;
    chk(d <= 32'h6, 32'h1);
    chk(actual_position, rv + shift);
  endtask : home_run

  // ==========================================================================
  // Clock and main sequence.
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  initial begin
    seed = 26;
    {rstn, reg_wr, reg_rd, supersede_req, place} = '0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    place_pos = 32'h0;
    axis_number = 4'h4;
    motor_feedback = 1'b1;
    following_error = $random(seed);
    shift = $random(seed) % 40;
    home = $random(seed);
    n_fail = 0;
    checks_done = 0;
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    rd(FAST_OFS);
    chk(rv, FAST_RST);
    rd(SLOW_OFS);
    chk(rv, SLOW_RST);
    rd(8'h1c);
    chk(rv, 32'h0);
    wr(SHIFT_OFS, shift);
    wr(HOME_OFS, home);
    rd(HOME_OFS);
    chk(rv, home);
    home_run(0, 300, 64, 1, FAST_RST);
    home_run(0, 50, 64, 0, FAST_RST);
    home_run(1, 200, 256, 0, SLOW_RST);
    home_run(2, 200, 192, 1, SLOW_RST);
    wr(CTRL_OFS, 32'h5);
    repeat (6) @(posedge ref_clk);
    #1 chk(homing_busy, 32'h0);
    start(1);
    wait_on(1'b0);
    @(posedge ref_clk);
    supersede_req <= 1'b1;
    @(posedge ref_clk);
    supersede_req <= 1'b0;
    #1 chk(superseded_flag, 32'h1);
    chk(motion_cmd.run, 32'h0);
    chk(homing_busy, 32'h0);
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      axis_number <= 4'(ax[i]);
      motor_feedback <= i != 1;
      start(me[i]);
      repeat (6) @(posedge ref_clk);
      #1 chk(method_error, 32'h1);
      chk(motion_cmd.run, 32'h0);
    end
    wrap_up();
  end
endmodule : tb_axis_homing_sequencer
